/* src/csrp_top.sv */
// Two-wire serial register port with its configuration register file
`timescale 1ns/1ps
`default_nettype none
module csrp_top (
   input  wire logic       ref_clk_in,
   input  wire logic       srst_in,
   input  wire logic       register_init_n_in,
   input  wire logic       slave_address_select_pin_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic [359:0]    config_regs_out
);
   // Link side: serial bus domain, clocked by scl_in edges, and by sda_in edges for start and stop
   logic [3:0]                 bit_cnt_ff;
   logic [7:0]                 shift_ff;
   logic [7:0]                 sub_ff;
   logic [7:0]                 tx_ff;
   logic                       ack_ff;
   logic                       drive_ff;
   logic                       wr_tog_ff;
   logic [7:0]                 wr_addr_ff;
   logic [7:0]                 wr_data_ff;
   logic                       rd_nack_ff;
   csrp_pkg::csrp_state_t      st_ff;
   logic                       start_tog_ff;
   logic                       start_seen_ff;
   logic                       stop_seen_ff;
   // System side
   logic [7:0]                 regs_ff [0:csrp_pkg::NUM_REGS-1];
   logic [2:0]                 wtog_sync_ff;
   logic [2:0]                 strap_sync_ff;
   logic                       init_active;
   logic                       init_done;

   // Decode of the byte in flight and of the read source
   wire  [7:0] rx_byte  = {shift_ff[6:0], sda_in};
   wire  [6:0] my_addr  = {csrp_pkg::ADDR_BASE[6:1], strap_sync_ff[1]};
   wire        sub_ok   = (sub_ff <= csrp_pkg::LAST_SUBADDR);
   wire  [7:0] rd_value = sub_ok ? regs_ff[sub_ff[5:0]] : csrp_pkg::REG_ZERO;
   wire        ack_slot = (bit_cnt_ff == csrp_pkg::ACK_BIT_IDX);

   // Sub-address step shared by write and read paths; wraps past FF
   function automatic logic [7:0] next_sub(input logic [7:0] sa);
      return sa + 8'h01;
   endfunction

   // Start and stop detection: sda edges while scl is high
   always_ff @(negedge sda_in or posedge srst_in) begin
      if (srst_in) begin
         start_tog_ff <= 1'b0;
      end else if (scl_in) begin
         start_tog_ff <= ~start_tog_ff;
      end
   end
   always_ff @(posedge sda_in or posedge srst_in) begin
      if (srst_in) begin
         stop_seen_ff <= 1'b0;
      end else begin
         stop_seen_ff <= scl_in ? 1'b1 : 1'b0;      // Stop ends the frame
      end
   end
   // Stop flag clears on the next sda rise with scl low, inside the next
   // frame; a frame whose leading bits were all zero would stay muted

   // Start toggles in the sda domain and is taken at the next scl rise
   logic start_ref_ff;
   wire  start_pend = (start_tog_ff != start_ref_ff);

   // Receive and transmit engine, sampled on rising scl
   always_ff @(posedge scl_in or posedge srst_in) begin
      if (srst_in) begin
         st_ff        <= csrp_pkg::CS_IDLE;
         bit_cnt_ff   <= 4'h0;
         shift_ff     <= 8'h00;
         sub_ff       <= 8'h00;
         wr_tog_ff    <= 1'b0;
         wr_addr_ff   <= 8'h00;
         wr_data_ff   <= 8'h00;
         rd_nack_ff   <= 1'b0;
         start_ref_ff <= 1'b0;
      end else if (start_pend) begin
         start_ref_ff <= start_tog_ff;
         st_ff        <= csrp_pkg::CS_ADDR;
         bit_cnt_ff   <= 4'h1;
         shift_ff     <= {7'h00, sda_in};
      end else begin
         bit_cnt_ff <= ack_slot ? 4'h0 : bit_cnt_ff + 4'h1;
         if (!ack_slot) begin
            shift_ff <= rx_byte;
         end
         // Bit counter runs 0 to 7 for data, 8 is the acknowledge slot
         case (st_ff)
            // Address mismatch mutes the port until the next start
            csrp_pkg::CS_ADDR: begin
               if (bit_cnt_ff == 4'h7) begin
                  if (rx_byte[7:1] != my_addr) begin
                     st_ff <= csrp_pkg::CS_IGNORE;
                  end
               end else if (ack_slot) begin
                  st_ff <= shift_ff[0] ? csrp_pkg::CS_RDATA : csrp_pkg::CS_SUB;
               end
            end
            csrp_pkg::CS_SUB: begin
               if (bit_cnt_ff == 4'h7) begin
                  sub_ff <= rx_byte;                 // Second byte is sub-address
               end else if (ack_slot) begin
                  st_ff <= csrp_pkg::CS_WDATA;
               end
            end
            csrp_pkg::CS_WDATA: begin
               if (bit_cnt_ff == 4'h7) begin
                  wr_addr_ff <= sub_ff;
                  wr_data_ff <= rx_byte;
                  wr_tog_ff  <= ~wr_tog_ff;
                  sub_ff     <= next_sub(sub_ff);    // Next data to next address
               end
            end
            csrp_pkg::CS_RDATA: begin
               if (ack_slot) begin
                  rd_nack_ff <= sda_in;              // Not-ack ends the read
                  if (sda_in) begin
                     st_ff <= csrp_pkg::CS_IGNORE;
                  end else begin
                     sub_ff <= next_sub(sub_ff);     // Advance after each acked byte
                  end
               end
            end
            default: begin
               st_ff <= st_ff;
            end
         endcase
      end
   end

   // Output drive updates on falling scl so sda moves only while scl low
   // Ack is skipped for a muted frame and for bytes the port itself sends
   always_ff @(negedge scl_in or posedge srst_in) begin
      if (srst_in) begin
         drive_ff <= 1'b0;
         ack_ff   <= 1'b0;
         tx_ff    <= 8'h00;
      end else if (stop_seen_ff) begin
         drive_ff <= 1'b0;
         ack_ff   <= 1'b0;
      end else if (bit_cnt_ff == 4'h8 && st_ff != csrp_pkg::CS_IGNORE && st_ff != csrp_pkg::CS_RDATA) begin
         drive_ff <= 1'b1;                           // Ack low on ninth clock
         ack_ff   <= 1'b1;
      end else if (st_ff == csrp_pkg::CS_RDATA && bit_cnt_ff == 4'h0) begin
         tx_ff    <= {rd_value[6:0], 1'b0};          // Read data from sub-address
         drive_ff <= ~rd_value[7];
         ack_ff   <= 1'b0;
      end else if (st_ff == csrp_pkg::CS_RDATA && bit_cnt_ff < 4'h8) begin
         tx_ff    <= {tx_ff[6:0], 1'b0};
         drive_ff <= ~tx_ff[7];
      end else begin
         drive_ff <= 1'b0;
         ack_ff   <= 1'b0;
      end
   end
   // Open drain: only ever pulls low
   assign sda_out    = 1'b0;
   assign sda_oe_out = drive_ff & ~stop_seen_ff;

   // Init pin qualifier: any low level holds defaults; only a qualified
   // pulse reloads them once more on its release
   csrp_init_reset u_init (
      .ref_clk_in         (ref_clk_in),
      .srst_in            (srst_in),
      .register_init_n_in (register_init_n_in),
      .init_active_out    (init_active),
      .init_done_out      (init_done)
   );

   // Write event crosses as a toggle; address and data are stable by then
   // Needs about four ref cycles between bytes, ample at fast-mode rates
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         wtog_sync_ff  <= 3'h0;
         strap_sync_ff <= 3'h0;
      end else begin
         wtog_sync_ff  <= {wtog_sync_ff[1:0], wr_tog_ff};
         strap_sync_ff <= {strap_sync_ff[1:0], slave_address_select_pin_in};
      end
   end

   // Edge of the synchronised toggle marks one landed byte
   wire wr_event = wtog_sync_ff[2] ^ wtog_sync_ff[1];

   // Register file: defaults on reset, while held, and on completion
   // Init wins over a write landing in the same cycle
   always_ff @(posedge ref_clk_in) begin
      for (int i = 0; i < csrp_pkg::NUM_REGS; i++) begin
         if (srst_in || init_active || init_done) begin
            regs_ff[i] <= csrp_pkg::DEFAULTS[i];
         end else if (wr_event && wr_addr_ff == 8'(i) && !csrp_pkg::is_read_only(wr_addr_ff)) begin
            regs_ff[i] <= wr_data_ff;
         end
      end
   end
   // Flatten the file so each register shows as its own byte
   genvar g;
   generate
      for (g = 0; g < csrp_pkg::NUM_REGS; g++) begin : g_flat
         assign config_regs_out[g*8 +: 8] = regs_ff[g];
      end
   endgenerate
endmodule
`default_nettype wire

/* pkg/csrp_pkg.sv */
// Constants and types for the control serial register port
package csrp_pkg;
   localparam logic [6:0] ADDR_BASE       = 7'h4C;  // 1001100, select pin adds bit 0
   localparam int         RST_MIN_NS      = 1000;   // Least init pulse width, ns
   localparam int         CLK_PERIOD_NS   = 40;     // ref_clk_in period, ns
   localparam int         RST_MIN_CYC     = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] RST_CNT_W1      = 6'(RST_MIN_CYC);
   localparam int         NUM_REGS        = 45;     // Sub-addresses 00 to 2C
   localparam logic [7:0] LAST_SUBADDR    = 8'h2C;
   localparam logic [3:0] ACK_BIT_IDX     = 4'h8;   // Ninth clock of a byte
   localparam logic [7:0] REG_ZERO        = 8'h00;
   // Default values by sub-address
   localparam logic [7:0] DEFAULTS [0:44] = '{
      8'hAE, 8'h69, 8'hD0, 8'h48, 8'h80, 8'h80, 8'h80, 8'h20,
      8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h40, 8'h4A,
      8'hB8, 8'h20, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01,
      8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00,
      8'hF0, 8'hA8, 8'h39, 8'h00, 8'h00};
   // Read-only sub-addresses
   function automatic logic is_read_only(input logic [7:0] sa);
      return (sa == 8'h00) || (sa >= 8'h0B && sa <= 8'h0D) || (sa == 8'h14) || (sa == 8'h2C);
   endfunction
   typedef enum logic [2:0] {CS_IDLE, CS_ADDR, CS_SUB, CS_WDATA, CS_RDATA, CS_IGNORE} csrp_state_t;
endpackage

/* src/csrp_init_reset.sv */
// Init reset qualifier: syncs the active-low init pin and filters pulses
`timescale 1ns/1ps
`default_nettype none
module csrp_init_reset (
   input  wire logic ref_clk_in,
   input  wire logic srst_in,
   input  wire logic register_init_n_in,
   output logic      init_active_out,
   output logic      init_done_out
);
   logic       sync1_ff;
   logic       sync2_ff;
   logic [5:0] cnt_ff;
   logic       act_ff;
   logic       done_ff;
   wire        low_now = ~sync2_ff;
   wire        long_enough = (cnt_ff >= csrp_pkg::RST_CNT_W1);
   wire  [5:0] nxt_cnt = low_now ? (long_enough ? cnt_ff : cnt_ff + 6'h01) : 6'h00;

   // Two flops before the pin is used; pulse is async to every clock
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         cnt_ff   <= 6'h00;
         act_ff   <= 1'b0;
         done_ff  <= 1'b0;
      end else begin
         sync1_ff <= register_init_n_in;
         sync2_ff <= sync1_ff;
         cnt_ff   <= nxt_cnt;
         act_ff   <= low_now;                        // Hold defaults while low
         done_ff  <= ~low_now & long_enough;         // Pulse over 1 us qualifies
      end
   end
   assign init_active_out = act_ff;
   assign init_done_out   = done_ff;
endmodule
`default_nettype wire

/* testbench/csrp_checker.sv */
// Checker for the serial register port
`timescale 1ns/1ps
`default_nettype none
module csrp_checker (
   input wire logic         ref_clk_in,
   input wire logic         srst_in,
   input wire logic         register_init_n_in,
   input wire logic         scl_in,
   input wire logic         sda_out,
   input wire logic         sda_oe_out,
   input wire logic [359:0] config_regs_out
);
   logic [359:0] def_w;
   logic         oe_hi_ff;
   logic         scl_q_ff;
   logic [3:0]   quiet_ff;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   // Flat image of the reset values
   for (genvar i = 0; i < 45; i++) begin : g_def
      assign def_w[8*i +: 8] = csrp_pkg::DEFAULTS[i];
   end
   // Drive level at scl rise, compared again at scl fall
   always_ff @(posedge scl_in or posedge srst_in) begin
      oe_hi_ff <= srst_in ? 1'b0 : sda_oe_out;
   end
   // Idle counter; registers may only move with scl or init activity
   always_ff @(posedge ref_clk_in) begin
      scl_q_ff <= scl_in;
      quiet_ff <= (srst_in || scl_q_ff != scl_in || !register_init_n_in) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
   end
   drive_scl_low_a: assert property (@(negedge scl_in) sda_oe_out == oe_hi_ff)
      else $error("sda drive moved while scl high");
   reset_release_a: assert property (disable iff (1'b0) srst_in |=> !sda_oe_out)
      else $error("sda driven after reset");
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   init_hold_a: assert property (!register_init_n_in [*4] |=> config_regs_out == def_w)
      else $error("defaults not held in init");
   reset_defaults_a: assert property ($fell(srst_in) |-> config_regs_out == def_w)
      else $error("defaults missing after reset");
   read_only_a: assert property (config_regs_out[7:0] == def_w[7:0] && config_regs_out[359:352] == 8'h00)
      else $error("read-only register moved");
   quiet_regs_a: assert property (quiet_ff == 4'hF |=> $stable(config_regs_out))
      else $error("registers moved on idle bus");
   idle_release_a: assert property (quiet_ff == 4'hF && scl_in |-> !sda_oe_out)
      else $error("sda held on idle bus");
   // Main traffic seen
   cover property ($rose(sda_oe_out));
   cover property ($changed(config_regs_out));
   cover property (!register_init_n_in [*8] ##1 register_init_n_in);
endmodule
bind csrp_top csrp_checker u_chk (.ref_clk_in, .srst_in, .register_init_n_in, .scl_in, .sda_out, .sda_oe_out,
   .config_regs_out);
`default_nettype wire

/* testbench/csrp_master.sv */
// Two-wire bus master model for the serial port
`timescale 1ns/1ps
`default_nettype none
module csrp_master (
   output var logic  scl_out,
   output var logic  sda_oe_out,
   input  wire logic sda_in
);
   // Bus parked released, scl high outside frames
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // One bit: sda moves only while scl is low
   task automatic bit_io(input logic b, output logic r);
      #16 sda_oe_out = ~b;
      #16 scl_out = 1'b1;
      #16 r = sda_in;
      #16 scl_out = 1'b0;
   endtask
   // Start or repeated start, sda falls with scl high
   task automatic start();
      #16 sda_oe_out = 1'b0;
      #16 scl_out = 1'b1;
      #16 sda_oe_out = 1'b1;
      #16 scl_out = 1'b0;
   endtask
   // Stop, sda rises with scl high
   task automatic stop();
      #16 sda_oe_out = 1'b1;
      #16 scl_out = 1'b1;
      #16 sda_oe_out = 1'b0;
      #16;
   endtask
   // Byte MSB first, then the ninth clock for acknowledge
   task automatic xfer(input logic [7:0] tx, input logic ak_tx, output logic [7:0] rx, output logic ak_rx);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ak_tx, ak_rx);
   endtask
endmodule
`default_nettype wire

/* testbench/csrp_top_test.sv */
// Self-checking bench for the serial register port
`timescale 1ns/1ps
`default_nettype none
module csrp_top_test;
   logic         clk;
   logic         srst;
   logic         init_n;
   logic         sel;
   logic         scl;
   logic         m_oe;
   logic         d_oe;
   logic [359:0] regs;
   wire logic    sda;
   int           fails;
   int           n_checks;
   // Open-drain wire with its pull-up
   assign sda = ~(m_oe | d_oe);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   csrp_top u_dut (.ref_clk_in(clk), .srst_in(srst), .register_init_n_in(init_n), .slave_address_select_pin_in(sel),
      .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(d_oe), .config_regs_out(regs));
   csrp_master u_m (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
   function automatic logic [7:0] rb(input logic [7:0] a);
      return regs[8*a +: 8];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Write frame; every byte expects the same acknowledge level
   task automatic wr(input logic [6:0] a, input logic [7:0] sa, d0, d1, input int n, input logic nak);
      logic [7:0] b [4];
      logic [7:0] rx;
      logic       ak;
      b = '{{a, 1'b0}, sa, d0, d1};
      u_m.start();
      for (int i = 0; i < n + 2; i++) begin
         u_m.xfer(b[i], 1'b1, rx, ak);
         chk({7'h00, ak}, {7'h00, nak});
      end
      u_m.stop();
      repeat (4) @(negedge clk);
   endtask
   // Sub-address write, repeated start, two bytes read, not-ack on the last
   task automatic rd(input logic [7:0] sa, e0, e1);
      logic [7:0] rx;
      logic       ak;
      u_m.start();
      u_m.xfer(8'h98, 1'b1, rx, ak);
      u_m.xfer(sa, 1'b1, rx, ak);
      u_m.start();
      u_m.xfer(8'h99, 1'b1, rx, ak);
      chk({7'h00, ak}, 8'h00);
      u_m.xfer(8'hFF, 1'b0, rx, ak);
      chk(rx, e0);
      u_m.xfer(8'hFF, 1'b1, rx, ak);
      chk(rx, e1);
      u_m.stop();
      repeat (4) @(negedge clk);
   endtask
   task automatic s_defaults();
      for (int i = 0; i < 45; i++) chk(rb(8'(i)), csrp_pkg::DEFAULTS[i]);
   endtask
   // Sequential writes, one running into read-only 2C, then reads past the end
   task automatic s_rw();
      wr(7'h4C, 8'h12, 8'hA5, 8'h3C, 2, 1'b0);
      chk(rb(8'h12), 8'hA5);
      chk(rb(8'h13), 8'h3C);
      wr(7'h4C, 8'h2B, 8'h0F, 8'h77, 2, 1'b0);
      chk(rb(8'h2B), 8'h0F);
      chk(rb(8'h2C), 8'h00);
      rd(8'h12, 8'hA5, 8'h3C);
      rd(8'h2C, 8'h00, 8'h00);
   endtask
   // Long init pulse holds and then restores the defaults
   task automatic s_init();
      wr(7'h4C, 8'h08, 8'h12, 8'h00, 1, 1'b0);
      init_n = 1'b0;
      repeat (30) @(negedge clk);
      chk(rb(8'h08), 8'h80);
      init_n = 1'b1;
      repeat (5) @(negedge clk);
      chk(rb(8'h08), 8'h80);
      chk(rb(8'h12), 8'h00);
   endtask
   // Each select level answers its own address only
   task automatic s_addr();
      for (int s = 0; s < 2; s++) begin
         sel = s[0];
         repeat (4) @(negedge clk);
         wr(7'h4D - 7'(s), 8'h05, 8'hEE, 8'h00, 1, 1'b1);
         wr(7'h4C + 7'(s), 8'h06, 8'h40 + 8'(s), 8'h00, 1, 1'b0);
         chk(rb(8'h05), 8'h80);
         chk(rb(8'h06), 8'h40 + 8'(s));
      end
   endtask
   // Hang guard, well above the expected 25 us run
   initial begin
      #200000;
      fails++;
      results();
   end
   initial begin
      srst = 1'b1;
      init_n = 1'b0;
      sel = 1'b0;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      repeat (26) @(negedge clk);
      init_n = 1'b1;
      repeat (4) @(negedge clk);
      s_defaults();
      s_rw();
      s_init();
      s_addr();
      results();
   end
endmodule
`default_nettype wire
